// >>> rtl/mfps_pkg.sv
// Purpose: Shared constants and types for the multi-function pin select block
// Assumes: 8-bit register address, 16-bit register data
// Notes:   Selector codes are 4 bits wide; codes above the last valid one are reserved
package mfps_pkg;

	// ==========================================================
	// Sizes
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 16;
	localparam int NUM_PINS    = 3;
	localparam int SEL_W       = 4;
	localparam int DIV_W       = 8;
	localparam int IRQ_FLAGS_W = 10;

	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] ADR_PIN1_CFG = 8'h79;
	localparam logic [ADDR_W-1:0] ADR_PIN2_CFG = 8'h7A;
	localparam logic [ADDR_W-1:0] ADR_PIN3_CFG = 8'h7B;
	localparam logic [ADDR_W-1:0] ADR_CLK_DIV  = 8'h90;
	localparam logic [ADDR_W-1:0] ADR_PIN_LVL  = 8'h91;

	// ==========================================================
	// Field positions
	localparam int SEL_LSB = 0;
	localparam int PD_BIT  = 4;
	localparam int PU_BIT  = 5;

	// ==========================================================
	// Function selector codes
	localparam logic [SEL_W-1:0] FN_INPUT     = 4'h0;
	localparam logic [SEL_W-1:0] FN_CLK_OUT   = 4'h1;
	localparam logic [SEL_W-1:0] FN_LOW       = 4'h2;
	localparam logic [SEL_W-1:0] FN_HIGH      = 4'h3;
	localparam logic [SEL_W-1:0] FN_IRQ       = 4'h4;
	localparam logic [SEL_W-1:0] FN_FLL_LOCK  = 4'h5;
	localparam logic [SEL_W-1:0] FN_MIC_DET   = 4'h6;
	localparam logic [SEL_W-1:0] FN_MIC_SHORT = 4'h7;
	localparam logic [SEL_W-1:0] FN_DIGITAL_MICROPHONE_CLK  = 4'h8;
	localparam logic [SEL_W-1:0] FN_FLL_CLK   = 4'h9;

	// ==========================================================
	// Reset values
	localparam logic [SEL_W-1:0] SEL_RST_PIN1  = FN_IRQ;
	localparam logic [SEL_W-1:0] SEL_RST_OTHER = FN_INPUT;
	localparam logic             PU_RST        = 1'b0;
	localparam logic             PD_RST        = 1'b1;
	localparam logic [DIV_W-1:0] DIV_RST       = 8'h04;
	localparam logic [DIV_W-1:0] DIV_MIN       = 8'h02;

	// ==========================================================
	// Types
	typedef struct packed
	{
		logic             pu;
		logic             pd;
		logic [SEL_W-1:0] sel;
	} mfps_pin_cfg_type;

	typedef mfps_pin_cfg_type [NUM_PINS-1:0] mfps_cfg_arr_type;

endpackage

// >>> rtl/mfps_src_if.sv
// Purpose: Carries the shared pin sources from the top to each pin slice
// Assumes: All signals are in the clk domain
// Notes:   One driver (top), many readers (pin slices)
`timescale 1ns/1ns
`default_nettype none
interface mfps_src_if;
	logic clk_out;
	logic irq;
	logic fll_lock;
	logic mic_det;
	logic mic_short;
	logic digital_microphone_clk;
	logic fll_clk;

	modport drive
	(
		output clk_out,
		output irq,
		output fll_lock,
		output mic_det,
		output mic_short,
		output digital_microphone_clk,
		output fll_clk
	);

	modport take
	(
		input clk_out,
		input irq,
		input fll_lock,
		input mic_det,
		input mic_short,
		input digital_microphone_clk,
		input fll_clk
	);
endinterface
`default_nettype wire

// >>> rtl/mfps_pin.sv
// Purpose: One pin slice: source select, registered drive, input synchroniser
// Assumes: Sources arrive on the clk domain; pin input is asynchronous
// Notes:   Pin drive comes from a flop so a source swap never glitches
`timescale 1ns/1ns
`default_nettype none
module mfps_pin
(
	input  wire logic                       clk,
	input  wire logic                       nrst,
	mfps_src_if.take                        src,
	input  wire mfps_pkg::mfps_pin_cfg_type cfg,
	input  wire logic                       pin_in,
	output logic                            pin_out,
	output logic                            pin_oe,
	output logic                            pin_pullup,
	output logic                            pin_pulldown,
	output logic                            pin_level
);

	// ==========================================================
	// State
	typedef struct packed
	{
		logic meta;
		logic sync;
		logic out;
		logic oe;
		logic pu;
		logic pd;
	} mfps_pin_st_type;

	mfps_pin_st_type st_r;
	mfps_pin_st_type st_nxt;

	// ==========================================================
	// Next state
	always_comb
	begin
		st_nxt      = st_r;
		st_nxt.meta = pin_in;
		st_nxt.sync = st_r.meta;
		st_nxt.pu   = cfg.pu;
		st_nxt.pd   = cfg.pd;
		st_nxt.oe   = 1'b1;
		// Registered mux: new source shows one edge after the write, no runt
		case (cfg.sel)
			mfps_pkg::FN_CLK_OUT:   st_nxt.out = src.clk_out;
			mfps_pkg::FN_LOW:       st_nxt.out = 1'b0;
			mfps_pkg::FN_HIGH:      st_nxt.out = 1'b1;
			mfps_pkg::FN_IRQ:       st_nxt.out = src.irq;
			mfps_pkg::FN_FLL_LOCK:  st_nxt.out = src.fll_lock;
			mfps_pkg::FN_MIC_DET:   st_nxt.out = src.mic_det;
			mfps_pkg::FN_MIC_SHORT: st_nxt.out = src.mic_short;
			mfps_pkg::FN_DIGITAL_MICROPHONE_CLK:  st_nxt.out = src.digital_microphone_clk;
			mfps_pkg::FN_FLL_CLK:   st_nxt.out = src.fll_clk;
			default:
			begin
				// Input pin, and reserved codes kept safe as inputs
				st_nxt.out = 1'b0;
				st_nxt.oe  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r <= '{meta: 1'b0, sync: 1'b0, out: 1'b0, oe: 1'b0,
				pu: mfps_pkg::PU_RST, pd: mfps_pkg::PD_RST};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign pin_out      = st_r.out;
	assign pin_oe       = st_r.oe;
	assign pin_pullup   = st_r.pu;
	assign pin_pulldown = st_r.pd;
	assign pin_level    = st_r.sync;

endmodule
`default_nettype wire

// >>> rtl/mfps_top.sv
// Purpose: Multi-function pin select: config registers, clock divider, pin slices
// Assumes: Single clk; register port with one-cycle read latency
// Notes:   Frequency-locked-loop clock is asynchronous and passes two flops
//
// Overview of operation
// - 4-bit selector per pin; 0000 input, 0010 drive low, 0011 drive high.
// - Code 0001 drives system clock divided by the larger of the output clock divisor and 2.
// - Code 0101 drives loop lock status; 1001 drives the loop output clock.
// - Codes 0110, 0111, 1000: mic detect, mic short, digital mic clock.
// - Code 0100 drives interrupt request; pin1 resets to 0100, others 0000.
// - Bit 5 is the pull-up enable, reset 0.
// - Bit 4 is the pull-down enable, reset 1.
// - Interrupt request is the OR of all interrupt status flags.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module mfps_top
(
	input  wire logic                               clk,
	input  wire logic                               nrst,
	input  wire logic [mfps_pkg::ADDR_W-1:0]        reg_addr,
	input  wire logic [mfps_pkg::DATA_W-1:0]        reg_wdata,
	input  wire logic                               reg_wr,
	input  wire logic                               reg_rd,
	output logic      [mfps_pkg::DATA_W-1:0]        reg_rdata,
	input  wire logic [mfps_pkg::IRQ_FLAGS_W-1:0]   irq_flags,
	input  wire logic                               fll_lock,
	input  wire logic                               fll_clk_in,
	input  wire logic                               mic_detect,
	input  wire logic                               mic_short,
	input  wire logic                               digital_microphone_clk,
	input  wire logic [mfps_pkg::NUM_PINS-1:0]      pin_in,
	output logic      [mfps_pkg::NUM_PINS-1:0]      pin_out,
	output logic      [mfps_pkg::NUM_PINS-1:0]      pin_oe,
	output logic      [mfps_pkg::NUM_PINS-1:0]      pin_pullup_enable,
	output logic      [mfps_pkg::NUM_PINS-1:0]      pin_pulldown_enable
);

	// ==========================================================
	// State
	typedef struct packed
	{
		mfps_pkg::mfps_cfg_arr_type       cfg;
		logic [mfps_pkg::DIV_W-1:0]       div;
		logic [mfps_pkg::DIV_W-1:0]       cnt;
		logic                             clk_out;
		logic                             fll_meta;
		logic                             fll_sync;
		logic                             irq;
		logic [mfps_pkg::DATA_W-1:0]      rdata;
	} mfps_top_st_type;

	mfps_top_st_type                  st_r;
	mfps_top_st_type                  st_nxt;
	logic [mfps_pkg::NUM_PINS-1:0]    pin_level;
	logic [mfps_pkg::DIV_W-1:0]       period;
	logic [mfps_pkg::DIV_W-1:0]       cnt_inc;

	mfps_src_if src ();

	// ==========================================================
	// Divider period, clamped so the output always toggles
	always_comb
	begin
		period  = (st_r.div < mfps_pkg::DIV_MIN) ? mfps_pkg::DIV_MIN : st_r.div;
		cnt_inc = st_r.cnt + 8'h01;
	end

	// ==========================================================
	// Register file, divider, crossings
	always_comb
	begin
		st_nxt          = st_r;
		st_nxt.fll_meta = fll_clk_in;
		st_nxt.fll_sync = st_r.fll_meta;
		st_nxt.irq      = |irq_flags;

		// Divider: output high for the first period/2 counts (rounded down) of each period
		if (cnt_inc >= period)
		begin
			st_nxt.cnt = '0;
		end
		else
		begin
			st_nxt.cnt = cnt_inc;
		end
		st_nxt.clk_out = (st_nxt.cnt < (period >> 1));

		// Writes land at the next edge
		if (reg_wr)
		begin
			if (reg_addr == mfps_pkg::ADR_PIN1_CFG)
			begin
				st_nxt.cfg[0] = reg_wdata[mfps_pkg::PU_BIT:mfps_pkg::SEL_LSB];
			end
			else if (reg_addr == mfps_pkg::ADR_PIN2_CFG)
			begin
				st_nxt.cfg[1] = reg_wdata[mfps_pkg::PU_BIT:mfps_pkg::SEL_LSB];
			end
			else if (reg_addr == mfps_pkg::ADR_PIN3_CFG)
			begin
				st_nxt.cfg[2] = reg_wdata[mfps_pkg::PU_BIT:mfps_pkg::SEL_LSB];
			end
			else if (reg_addr == mfps_pkg::ADR_CLK_DIV)
			begin
				// Restart so the new rate starts on a clean period
				st_nxt.div     = reg_wdata[mfps_pkg::DIV_W-1:0];
				st_nxt.cnt     = '0;
				st_nxt.clk_out = 1'b1;
			end
		end

		// Read data stands for exactly one cycle; unmapped reads give zero
		st_nxt.rdata = '0;
		if (reg_rd)
		begin
			if (reg_addr == mfps_pkg::ADR_PIN1_CFG)
			begin
				st_nxt.rdata[mfps_pkg::PU_BIT:mfps_pkg::SEL_LSB] = st_r.cfg[0];
			end
			else if (reg_addr == mfps_pkg::ADR_PIN2_CFG)
			begin
				st_nxt.rdata[mfps_pkg::PU_BIT:mfps_pkg::SEL_LSB] = st_r.cfg[1];
			end
			else if (reg_addr == mfps_pkg::ADR_PIN3_CFG)
			begin
				st_nxt.rdata[mfps_pkg::PU_BIT:mfps_pkg::SEL_LSB] = st_r.cfg[2];
			end
			else if (reg_addr == mfps_pkg::ADR_CLK_DIV)
			begin
				st_nxt.rdata[mfps_pkg::DIV_W-1:0] = st_r.div;
			end
			else if (reg_addr == mfps_pkg::ADR_PIN_LVL)
			begin
				st_nxt.rdata[mfps_pkg::NUM_PINS-1:0] = pin_level;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r          <= '0;
			st_r.cfg[0]   <= '{pu: mfps_pkg::PU_RST, pd: mfps_pkg::PD_RST, sel: mfps_pkg::SEL_RST_PIN1};
			st_r.cfg[1]   <= '{pu: mfps_pkg::PU_RST, pd: mfps_pkg::PD_RST, sel: mfps_pkg::SEL_RST_OTHER};
			st_r.cfg[2]   <= '{pu: mfps_pkg::PU_RST, pd: mfps_pkg::PD_RST, sel: mfps_pkg::SEL_RST_OTHER};
			st_r.div      <= mfps_pkg::DIV_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Shared sources; loop clock is only as good as clk/2 after sampling
	assign src.clk_out   = st_r.clk_out;
	assign src.irq       = st_r.irq;
	assign src.fll_lock  = fll_lock;
	assign src.mic_det   = mic_detect;
	assign src.mic_short = mic_short;
	assign src.digital_microphone_clk  = digital_microphone_clk;
	assign src.fll_clk   = st_r.fll_sync;
	assign reg_rdata     = st_r.rdata;

	// ==========================================================
	// Pin slices
	for (genvar i = 0; i < mfps_pkg::NUM_PINS; i++)
	begin : g_pin
		mfps_pin u_pin
		(
			.clk          (clk),
			.nrst         (nrst),
			.src          (src),
			.cfg          (st_r.cfg[i]),
			.pin_in       (pin_in[i]),
			.pin_out      (pin_out[i]),
			.pin_oe       (pin_oe[i]),
			.pin_pullup   (pin_pullup_enable[i]),
			.pin_pulldown (pin_pulldown_enable[i]),
			.pin_level    (pin_level[i])
		);
	end

endmodule
`default_nettype wire

// >>> verification/mfps_board.sv
// Purpose: Board logic on the three pins
// Assumes: Pin drive wins over external drive
// Notes:   Floating pins wander
`timescale 1ns/1ns
`default_nettype none
module mfps_board
(
	input  wire logic       clk,
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe,
	input  wire logic [2:0] pu,
	input  wire logic [2:0] pd,
	input  wire logic [2:0] ext_en,
	input  wire logic [2:0] ext_lvl,
	output logic      [2:0] pin_lvl
);
	// ======
	// Wire level
	logic [2:0] wander_r = 3'h5;
	always_ff @(posedge clk)
		wander_r <= ~wander_r;
	always_comb
		for (int i = 0; i < 3; i++)
			pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_lvl[i] : pu[i] | (!pd[i] & wander_r[i]);
endmodule
`default_nettype wire

// >>> verification/mfps_top_checker.sv
// Purpose: Port assertions for mfps_top
// Assumes: Pin 0 config shadowed from writes
// Notes:   Source checks wait three edges
`timescale 1ns/1ns
`default_nettype none
module mfps_top_checker
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [9:0]  irq_flags,
	input wire logic        fll_lock,
	input wire logic        mic_detect,
	input wire logic [2:0]  pin_out,
	input wire logic [2:0]  pin_oe,
	input wire logic [2:0]  pin_pullup_enable,
	input wire logic [2:0]  pin_pulldown_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ======
	// Shadow and settle count
	logic [5:0] c0_r;
	logic [1:0] hold_r;
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			c0_r <= 6'h14;
		else if (reg_wr && reg_addr == 8'h79)
			c0_r <= reg_wdata[5:0];
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			hold_r <= 2'h0;
		else if (reg_wr && reg_addr == 8'h79)
			hold_r <= 2'h0;
		else if (hold_r != 2'h3)
			hold_r <= hold_r + 2'h1;
	// ======
	// Assertions
	a_drive_low: assert property (reg_wr && reg_addr == 8'h79 && reg_wdata[3:0] == 4'h2
		|-> ##2 pin_oe[0] && !pin_out[0]) else $error("pin0 not low");
	a_drive_high: assert property (reg_wr && reg_addr == 8'h7A && reg_wdata[3:0] == 4'h3
		|-> ##2 pin_oe[1] && pin_out[1]) else $error("pin1 not high");
	a_input_float: assert property (reg_wr && reg_addr == 8'h7B && reg_wdata[3:0] == 4'h0
		|-> ##2 !pin_oe[2]) else $error("pin2 driven");
	a_irq_route: assert property (hold_r == 2'h3 && c0_r[3:0] == 4'h4
		|-> pin_oe[0] && pin_out[0] == $past(|irq_flags, 2)) else $error("irq route");
	a_lock_route: assert property (hold_r == 2'h3 && c0_r[3:0] == 4'h5
		|-> pin_oe[0] && pin_out[0] == $past(fll_lock)) else $error("lock route");
	a_mic_route: assert property (hold_r == 2'h3 && c0_r[3:0] == 4'h6
		|-> pin_oe[0] && pin_out[0] == $past(mic_detect)) else $error("mic route");
	a_pull_follow: assert property (hold_r == 2'h3
		|-> pin_pullup_enable[0] == c0_r[5] && pin_pulldown_enable[0] == c0_r[4]) else $error("pulls");
	a_cfg_readback: assert property (reg_rd && reg_addr == 8'h79
		|=> reg_rdata == {10'h000, $past(c0_r)}) else $error("readback");
endmodule
bind mfps_top mfps_top_checker u_chk (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.irq_flags, .fll_lock, .mic_detect, .pin_out, .pin_oe, .pin_pullup_enable, .pin_pulldown_enable);
`default_nettype wire

// >>> verification/multi_function_pin_select_tb_top.sv
// Purpose: Random and corner tests of mfps_top
// Assumes: Board model on the pins
// Notes:   Clock sources counted by rising edges
`timescale 1ns/1ns
`default_nettype none
module multi_function_pin_select_tb_top;
	logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [9:0]  irq_flags = 10'h000;
	logic        fll_lock = 1'b0, fll_clk_in = 1'b0, mic_detect = 1'b0, mic_short = 1'b0, digital_microphone_clk = 1'b0;
	logic [2:0]  pin_in, pin_out, pin_oe, pu, pd, ext_lvl = 3'h0, fcnt = 3'h0, ext_en = 3'h7;
	logic [31:0] seed = 32'hBC34F3CE;
	logic [3:0]  code;
	int          errors = 0, cmp_count = 0, n, p;
	// ======
	// Clocks and instances
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		fcnt <= (fcnt == 3'h2) ? 3'h0 : fcnt + 3'h1;
		fll_clk_in <= fll_clk_in ^ (fcnt == 3'h2);
	end
	mfps_top u_dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_flags, .fll_lock,
		.fll_clk_in, .mic_detect, .mic_short, .digital_microphone_clk, .pin_in, .pin_out, .pin_oe,
		.pin_pullup_enable(pu), .pin_pulldown_enable(pd));
	mfps_board u_board (.clk, .pin_out, .pin_oe, .pu, .pd, .ext_en, .ext_lvl, .pin_lvl(pin_in));
	// ======
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [1:0] drive(input logic [3:0] c);
		case (c)
			4'h1, 4'h2, 4'h9: return 2'b10;
			4'h3: return 2'b11;
			4'h4: return {1'b1, |irq_flags};
			4'h5: return {1'b1, fll_lock};
			4'h6: return {1'b1, mic_detect};
			4'h7: return {1'b1, mic_short};
			4'h8: return {1'b1, digital_microphone_clk};
			default: return 2'b00;
		endcase
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask
	task automatic rises(input int cyc);
		int r;
		logic last;
		r = 0;
		// Take the reference level off the edge so no rise is lost to a race
		@(negedge clk);
		last = pin_out[p];
		repeat (cyc)
		begin
			@(negedge clk);
			r += int'(pin_out[p] & !last);
			last = pin_out[p];
		end
		chk(16'(r), 16'h0008);
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ======
	// Sequence; whole run is under a thousand cycles
	initial
	begin
		#100000;
		errors++;
		conclude();
	end
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rd(8'h79, 16'h0014);
		rd(8'h7A, 16'h0010);
		rd(8'h7B, 16'h0010);
		rd(8'h55, 16'h0000);
		for (n = 0; n < 40; n++)
		begin
			seed = xs(seed);
			p = int'(seed[17:16]) % 3;
			code = (n < 10) ? n[3:0] : 4'(seed[3:0] % 4'hA);
			@(posedge clk);
			irq_flags <= seed[13:4] & {10{seed[14]}};
			{fll_lock, mic_detect, mic_short, digital_microphone_clk} <= seed[23:20];
			wr(8'h79 + 8'(p), {10'h000, seed[28:27], code});
			repeat (4) @(posedge clk);
			@(negedge clk);
			chk(16'({pin_oe[p], pin_out[p] & code != 4'h1 & code != 4'h9, pu[p], pd[p]}), 16'({drive(code), seed[28:27]}));
			rd(8'h79 + 8'(p), {10'h000, seed[28:27], code});
		end
		p = 1;
		for (n = 2; n < 7; n++)
		begin
			wr(8'h90, 16'(n));
			wr(8'h7A, 16'h0011);
			repeat (4) @(posedge clk);
			rises(8 * n);
		end
		p = 2;
		wr(8'h7B, 16'h0019);
		repeat (8) @(posedge clk);
		rises(48);
		wr(8'h79, 16'h0012);
		wr(8'h7A, 16'h0013);
		wr(8'h7B, 16'h0020);
		ext_en <= 3'h3;
		repeat (6) @(posedge clk);
		rd(8'h91, 16'h0006);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		rd(8'h79, 16'h0014);
		rd(8'h91, {15'h0000, |irq_flags});
		conclude();
	end
endmodule
`default_nettype wire
